/* File: common/lptc_pkg.sv */
`default_nettype none

package lptc_pkg;

  // ***********************
  // pixel and lane layout
  // ***********************
  localparam int PIX_W = 18;
  localparam int LANE_W = 7;
  localparam int HS_BIT = 18;
  localparam int VS_BIT = 19;
  localparam int DE_BIT = 20;

  // ***********************
  // output timing (CLK_I cycles)
  // ***********************
  localparam logic [5:0] POL_LIMIT = 6'h12; // 18 toggling bits
  localparam logic [5:0] HCLK_SETUP = 6'h04;
  localparam logic [5:0] HCLK_HIGH = 6'h08;
  localparam logic [5:0] HCLK_END = HCLK_SETUP + HCLK_HIGH;
  localparam logic [5:0] PCNT_MAX = 6'h3f;
  localparam logic [3:0] LATCH_CYC = 4'h8;
  localparam logic [3:0] OE_CYC = 4'h8;
  localparam logic [3:0] GCLK_CYC = 4'h8;
  localparam logic [8:0] IDLE_LIMIT = 9'h100;

  // ***********************
  // register map
  // ***********************
  localparam logic [1:0] CTRL_IDX = 2'h0; // byte 0x0
  localparam logic [1:0] STAT_IDX = 2'h1; // byte 0x4
  localparam logic [1:0] FCNT_IDX = 2'h2; // byte 0x8
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_LINV_BIT = 1;
  localparam int CTRL_SSC_BIT = 2;
  localparam int CTRL_TWOPOL_BIT = 3;
  localparam int CTRL_BLANK_BIT = 4;
  localparam int CTRL_SHIFT_LSB = 8;
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_BLANK_BIT = 1;
  localparam int STAT_LINK_BIT = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // two pixels sorted into odd and even order
  typedef struct packed {
    logic [PIX_W-1:0] odd;
    logic [PIX_W-1:0] even;
    logic de;
    logic hs;
    logic vs;
    logic first;
  } lptc_pair_s;

  // formatting options
  typedef struct packed {
    logic pol_en;
    logic linv_en;
    logic ssc_en;
    logic two_pol;
    logic [3:0] shift;
  } lptc_cfg_s;

  // number of set bits in a double word
  function automatic logic [5:0] lptc_ones(input logic [35:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 36; i++) begin
      n = n + {5'h00, v[i]};
    end
    return n;
  endfunction : lptc_ones

endpackage : lptc_pkg

`default_nettype wire

/* File: logic/lptc_top.sv */
`timescale 1ns/10ps
`default_nettype none

// ***********************
// link side receiver
// ***********************
module lptc_link_rx
  import lptc_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic [LANE_W-1:0] lane0_i,
  input wire logic [LANE_W-1:0] lane1_i,
  input wire logic [LANE_W-1:0] lane2_i,
  output lptc_pair_s pair_o,
  output logic tog_o
);

  typedef struct packed {
    logic [1:0] rsync;
    logic de_prev;
    logic phase;
    logic [PIX_W-1:0] odd_hold;
    logic first_hold;
    lptc_pair_s pair;
    logic tog;
  } lptc_link_s;

  lptc_link_s st;
  lptc_link_s nx;
  logic [3*LANE_W-1:0] pix;
  logic starts;

  // unpack lanes, pair pixels, flag each finished pair by a toggle
  always_comb begin
    nx = st;
    pix = {lane2_i, lane1_i, lane0_i};
    starts = pix[DE_BIT] && !st.de_prev;
    nx.rsync = {st.rsync[0], rst_i};
    nx.de_prev = pix[DE_BIT];
    if (starts || !st.phase) begin
      // a line always begins on the odd bus
      nx.odd_hold = pix[PIX_W-1:0];
      nx.first_hold = starts;
      nx.phase = 1'b1;
    end else begin
      nx.pair.odd = st.odd_hold;
      nx.pair.even = pix[PIX_W-1:0];
      nx.pair.de = pix[DE_BIT];
      nx.pair.hs = pix[HS_BIT];
      nx.pair.vs = pix[VS_BIT];
      nx.pair.first = st.first_hold;
      nx.tog = !st.tog;
      nx.phase = 1'b0;
    end
    if (st.rsync[1]) begin
      nx = '0;
      nx.rsync = {st.rsync[0], rst_i};
    end
  end

  // pair stays put for two link cycles, long enough for the far side
  always_ff @(posedge link_clk_i) begin
    st <= nx;
  end

  assign pair_o = st.pair;
  assign tog_o = st.tog;

endmodule : lptc_link_rx

// ***********************
// timing controller top
// ***********************
module lptc_top
  import lptc_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [3:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [3:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  input wire logic LINK_CLK_I,
  input wire logic [LANE_W-1:0] LANE0_I,
  input wire logic [LANE_W-1:0] LANE1_I,
  input wire logic [LANE_W-1:0] LANE2_I,
  output logic [PIX_W-1:0] ODD_DATA_O,
  output logic [PIX_W-1:0] EVEN_DATA_O,
  output logic ODD_POL_O,
  output logic EVEN_POL_O,
  output logic ODD_LINE_INVERT_O,
  output logic EVEN_LINE_INVERT_O,
  output logic ODD_HSTART_PULSE_O,
  output logic EVEN_HSTART_PULSE_O,
  output logic ODD_HCLK_OUT_O,
  output logic EVEN_HCLK_OUT_O,
  output logic SHIFTED_DATA_CLOCK_O,
  output logic COL_LATCH_PULSE_O,
  output logic COL_OUT_ENABLE_O,
  output logic GATE_CLOCK_O,
  output logic GATE_START_O,
  output logic GATE_ENABLE_A_O,
  output logic GATE_ENABLE_B_O,
  output logic DRV_CLEAR_O
);

  typedef struct packed {
    logic [2:0] tsync;
    lptc_cfg_s ctrl;
    logic soft_blank;
    lptc_cfg_s cfg;
    logic [15:0] fcount;
    lptc_pair_s pend;
    logic [35:0] prev;
    logic [PIX_W-1:0] odd_q;
    logic [PIX_W-1:0] even_q;
    logic pol_q;
    logic out_de;
    logic [5:0] pcnt;
    logic hclk;
    logic [15:0] hist;
    logic shifted_data_clock;
    logic hstart;
    logic line_tog;
    logic [3:0] lcnt;
    logic [3:0] ocnt;
    logic [3:0] gcnt;
    logic vstart;
    logic valid;
    logic blank;
    logic de_seen;
    logic hs_seen;
    logic vs_prev;
    logic [8:0] idle;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } lptc_sys_s;

  lptc_sys_s st;
  lptc_sys_s nx;
  lptc_pair_s pair;
  logic tog;
  logic ev;
  logic frame_ev;
  logic wr_go;
  logic rd_go;
  logic live;
  logic run;
  logic inv;
  logic [35:0] cand;
  logic [35:0] word;

  lptc_link_rx u_link (
    .link_clk_i(LINK_CLK_I),
    .rst_i(RST_I),
    .lane0_i(LANE0_I),
    .lane1_i(LANE1_I),
    .lane2_i(LANE2_I),
    .pair_o(pair),
    .tog_o(tog)
  );

  // ***********************
  // events and bus handshakes
  // ***********************
  // toggle edge seen after two flops; pair word is stable by then
  assign ev = st.tsync[2] ^ st.tsync[1];
  assign frame_ev = ev && pair.vs && !st.vs_prev;
  assign wr_go = AWVALID_I && WVALID_I && !st.bvalid;
  assign rd_go = ARVALID_I && !st.rvalid;
  assign live = st.valid && !st.blank;

  // ***********************
  // next state
  // ***********************
  always_comb begin
    nx = st;
    cand = {st.pend.odd, st.pend.even};
    inv = st.cfg.pol_en && (lptc_ones(cand ^ st.prev) > POL_LIMIT);
    word = inv ? ~cand : cand;
    nx.tsync = {st.tsync[1:0], tog};
    // counters between pairs; each stops at its limit
    if (st.pcnt != PCNT_MAX) begin
      nx.pcnt = st.pcnt + 6'h01;
    end
    // silent link drops valid video
    if (st.idle != IDLE_LIMIT) begin
      nx.idle = st.idle + 9'h001;
    end else begin
      nx.valid = 1'b0;
    end
    if (st.ocnt != 4'h0) begin
      nx.ocnt = st.ocnt - 4'h1;
    end
    if (st.lcnt != 4'h0) begin
      nx.lcnt = st.lcnt - 4'h1;
      if (st.lcnt == 4'h1) begin
        nx.ocnt = OE_CYC;
      end
    end
    if (st.gcnt != 4'h0) begin
      nx.gcnt = st.gcnt - 4'h1;
    end
    // one pixel pair per event; the pending pair gives one period of lead
    if (ev) begin
      nx.idle = 9'h000;
      nx.pcnt = 6'h00;
      nx.odd_q = word[35:18];
      nx.even_q = word[17:0];
      nx.prev = word;
      nx.pol_q = inv;
      nx.out_de = st.pend.de;
      if (st.out_de && !st.pend.de) begin
        nx.lcnt = LATCH_CYC;
      end
      nx.pend = pair;
      nx.hstart = pair.first;
      nx.vs_prev = pair.vs;
      nx.de_seen = st.de_seen | pair.de;
      nx.hs_seen = st.hs_seen | pair.hs;
      if (pair.first) begin
        nx.line_tog = !st.line_tog;
        nx.gcnt = GCLK_CYC;
        nx.vstart = 1'b0;
      end
    end
    // frame start: detection verdict, option latch, vertical start
    if (frame_ev) begin
      nx.fcount = st.fcount + 16'h0001;
      nx.cfg = st.ctrl;
      nx.valid = st.de_seen && st.hs_seen;
      nx.de_seen = 1'b0;
      nx.hs_seen = 1'b0;
      nx.vstart = 1'b1;
      nx.line_tog = 1'b0;
      if (!st.soft_blank) begin
        nx.blank = 1'b0;
      end
    end
    if (st.soft_blank) begin
      nx.blank = 1'b1;
    end
    // write channel: address and data taken together
    if (st.bvalid && BREADY_I) begin
      nx.bvalid = 1'b0;
    end
    if (wr_go) begin
      nx.bvalid = 1'b1;
      nx.bresp = RESP_OKAY;
      case (AWADDR_I[3:2])
        CTRL_IDX: begin
          if (WSTRB_I[0]) begin
            nx.ctrl.pol_en = WDATA_I[CTRL_POL_BIT];
            nx.ctrl.linv_en = WDATA_I[CTRL_LINV_BIT];
            nx.ctrl.ssc_en = WDATA_I[CTRL_SSC_BIT];
            nx.ctrl.two_pol = WDATA_I[CTRL_TWOPOL_BIT];
            nx.soft_blank = WDATA_I[CTRL_BLANK_BIT];
          end
          if (WSTRB_I[1]) begin
            nx.ctrl.shift = WDATA_I[CTRL_SHIFT_LSB +: 4];
          end
        end
        STAT_IDX, FCNT_IDX: begin
          nx.bresp = RESP_OKAY; // read only, write ignored
        end
        default: begin
          nx.bresp = RESP_SLVERR;
        end
      endcase
    end
    // read channel
    if (st.rvalid && RREADY_I) begin
      nx.rvalid = 1'b0;
    end
    if (rd_go) begin
      nx.rvalid = 1'b1;
      nx.rresp = RESP_OKAY;
      nx.rdata = 32'h0000_0000;
      case (ARADDR_I[3:2])
        CTRL_IDX: begin
          nx.rdata[CTRL_POL_BIT] = st.ctrl.pol_en;
          nx.rdata[CTRL_LINV_BIT] = st.ctrl.linv_en;
          nx.rdata[CTRL_SSC_BIT] = st.ctrl.ssc_en;
          nx.rdata[CTRL_TWOPOL_BIT] = st.ctrl.two_pol;
          nx.rdata[CTRL_BLANK_BIT] = st.soft_blank;
          nx.rdata[CTRL_SHIFT_LSB +: 4] = st.ctrl.shift;
        end
        STAT_IDX: begin
          nx.rdata[STAT_VALID_BIT] = st.valid;
          nx.rdata[STAT_BLANK_BIT] = st.blank;
          nx.rdata[STAT_LINK_BIT] = st.idle != IDLE_LIMIT;
        end
        FCNT_IDX: begin
          nx.rdata[15:0] = st.fcount;
        end
        default: begin
          nx.rresp = RESP_SLVERR;
        end
      endcase
    end
    // clocks; delay tap chosen by the shift field
    run = nx.valid && !nx.blank;
    nx.hclk = run && nx.pcnt >= HCLK_SETUP && nx.pcnt < HCLK_END;
    nx.hist = {st.hist[14:0], st.hclk};
    nx.shifted_data_clock = run && (st.cfg.ssc_en ? st.hist[st.cfg.shift] : st.hclk);
    // blank everything while video is not good, drivers get cleared while blank is set
    if (!run) begin
      nx.odd_q = '0;
      nx.even_q = '0;
      nx.pol_q = 1'b0;
      nx.hstart = 1'b0;
      nx.lcnt = 4'h0;
      nx.ocnt = 4'h0;
      nx.gcnt = 4'h0;
      nx.vstart = 1'b0;
    end
    if (RST_I) begin
      nx = '0;
      nx.blank = 1'b1;
      nx.idle = IDLE_LIMIT;
    end
  end

  always_ff @(posedge CLK_I) begin
    st <= nx;
  end

  // ***********************
  // outputs
  // ***********************
  assign AWREADY_O = wr_go;
  assign WREADY_O = wr_go;
  assign BVALID_O = st.bvalid;
  assign BRESP_O = st.bresp;
  assign ARREADY_O = rd_go;
  assign RVALID_O = st.rvalid;
  assign RRESP_O = st.rresp;
  assign RDATA_O = st.rdata;
  // column driver side
  assign ODD_DATA_O = st.odd_q;
  assign EVEN_DATA_O = st.even_q;
  assign ODD_POL_O = st.pol_q;
  assign EVEN_POL_O = st.pol_q && st.cfg.two_pol;
  assign ODD_LINE_INVERT_O = live && st.cfg.linv_en && st.line_tog;
  assign EVEN_LINE_INVERT_O = live && st.cfg.linv_en && !st.line_tog;
  assign ODD_HSTART_PULSE_O = st.hstart;
  assign EVEN_HSTART_PULSE_O = st.hstart;
  assign ODD_HCLK_OUT_O = st.hclk;
  assign EVEN_HCLK_OUT_O = st.hclk;
  assign SHIFTED_DATA_CLOCK_O = st.shifted_data_clock;
  assign COL_LATCH_PULSE_O = st.lcnt != 4'h0;
  assign COL_OUT_ENABLE_O = st.ocnt != 4'h0;
  // gate driver side; rows stay off during row switching
  assign GATE_CLOCK_O = st.gcnt != 4'h0;
  assign GATE_START_O = st.vstart;
  assign GATE_ENABLE_A_O = live && st.gcnt == 4'h0;
  assign GATE_ENABLE_B_O = live && st.gcnt == 4'h0 && st.ocnt == 4'h0;
  assign DRV_CLEAR_O = st.blank;

  // ***********************
  // checks
  // ***********************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_hclk_low;
    !ODD_HCLK_OUT_O [*4];
  endsequence
  sequence s_hclk_high;
    ODD_HCLK_OUT_O [*8] ##1 !ODD_HCLK_OUT_O;
  endsequence

  a_pair_order: assert property (ev |=> st.pend == $past(pair))
    else $error("pair not taken in order");
  a_pol_limit: assert property (ev && live && st.cfg.pol_en |=>
    lptc_ones(st.prev ^ $past(st.prev)) <= POL_LIMIT)
    else $error("too many bus transitions");
  a_line_inv: assert property (live && st.cfg.linv_en |->
    ODD_LINE_INVERT_O != EVEN_LINE_INVERT_O)
    else $error("line inversion outputs equal");
  a_hstart_lead: assert property (ev && ODD_HSTART_PULSE_O && live |=> st.out_de)
    else $error("start pulse not followed by data");
  a_hclk_shape: assert property (st.pcnt == 6'h00 && live |->
    s_hclk_low ##1 s_hclk_high)
    else $error("horizontal clock shape wrong");
  a_latch_oe: assert property ($fell(COL_LATCH_PULSE_O) && live |-> COL_OUT_ENABLE_O)
    else $error("output enable missing after latch");
  a_gate_clock: assert property ($rose(GATE_CLOCK_O) && live |->
    GATE_CLOCK_O [*8] ##1 !GATE_CLOCK_O)
    else $error("gate clock width wrong");
  a_frame_start: assert property (frame_ev |=>
    st.fcount == $past(st.fcount) + 16'h0001 && (GATE_START_O || !live))
    else $error("vertical start missing");
  a_valid_src: assert property ($rose(st.valid) |-> $past(frame_ev))
    else $error("valid raised outside frame start");
  a_blank_out: assert property (st.blank |-> DRV_CLEAR_O && ODD_DATA_O == '0 &&
    !GATE_ENABLE_A_O && !COL_LATCH_PULSE_O && !GATE_START_O)
    else $error("outputs not blank");
  a_cfg_hold: assert property (!frame_ev |=> $stable(st.cfg))
    else $error("options changed mid frame");

endmodule : lptc_top

`default_nettype wire

/* File: test/lptc_link_model.sv */
`timescale 1ns/10ps
`default_nettype none

// **********
// host link source
// **********
module lptc_link_model
  import lptc_pkg::*;
(
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic alt_i,
  output logic [LANE_W-1:0] lane0_o,
  output logic [LANE_W-1:0] lane1_o,
  output logic [LANE_W-1:0] lane2_o,
  output logic exp_o,
  output logic [36:0] exp_pix_o,
  output logic [7:0] frame_o
);
  logic [4:0] col;
  logic [2:0] row;
  logic act, alt, hs, vs, de;
  logic [PIX_W-1:0] pix, odd;

  // 28 pixels a line, 5 lines a frame; even counts keep the pairs aligned
  assign hs = act && col < 5'h04;
  assign vs = act && row == 3'h0;
  assign de = act && row != 3'h0 && col >= 5'h08 && col < 5'h18;

  // frames start only at a frame boundary; blanking data keeps toggling
  always @(posedge link_clk_i) begin
    exp_o <= 1'b0;
    if (rst_i) begin
      col <= 5'h00;
      row <= 3'h0;
      act <= 1'b0;
      alt <= 1'b0;
      frame_o <= 8'h00;
      pix = '0;
    end else begin
      col <= (col == 5'h1b) ? 5'h00 : col + 5'h01;
      if (col == 5'h1b) row <= (row == 3'h4) ? 3'h0 : row + 3'h1;
      if (col == 5'h1b && row == 3'h4) begin
        act <= run_i;
        alt <= alt_i;
        frame_o <= frame_o + {7'h00, run_i};
      end
      pix = !de ? ~pix : alt ? {PIX_W{col[1]}} : PIX_W'($urandom);
      if (de && !col[0]) odd <= pix;
      if (de && col[0]) begin
        exp_o <= frame_o > 8'h02; // earlier frames may still be blank
        exp_pix_o <= {alt, odd, pix};
      end
    end
    {lane2_o, lane1_o, lane0_o} <= {de, vs, hs, pix};
  end
endmodule : lptc_link_model

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

// **********
// bench top
// **********
module tb_top
  import lptc_pkg::*;
;
  logic clk, rst, lclk, awvalid, wvalid, bready, arvalid, rready, run, alt, xv;
  logic awready, wready, bvalid, arready, rvalid, odd_pol, even_pol, odd_inv, even_inv;
  logic odd_hs, even_hs, odd_hc, even_hc, sclk, lat, oen, gclk, gst, gea, geb, clr;
  logic hc_q, lat_q, gs_q, sc_q, cur_alt, p;
  logic [3:0] awaddr, araddr, wstrb, sh;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp;
  logic [LANE_W-1:0] ln0, ln1, ln2;
  logic [PIX_W-1:0] odd_d, even_d;
  logic [36:0] xp, e;
  logic [33:0] xr;
  logic [35:0] prev, w;
  logic [7:0] frame;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [36:0] pq[$];
  int n_mismatch, cmp_count, left, nline, nlat, gs_line, gap, lat_n, k;

  // system clock 4 ns; link clock 64 ns at an unrelated phase
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #13;
    forever #32 lclk = ~lclk;
  end

  lptc_top dut_u (
    .CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr),
    .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp),
    .RVALID_O(rvalid), .RREADY_I(rready), .LINK_CLK_I(lclk), .LANE0_I(ln0),
    .LANE1_I(ln1), .LANE2_I(ln2), .ODD_DATA_O(odd_d), .EVEN_DATA_O(even_d),
    .ODD_POL_O(odd_pol), .EVEN_POL_O(even_pol), .ODD_LINE_INVERT_O(odd_inv),
    .EVEN_LINE_INVERT_O(even_inv), .ODD_HSTART_PULSE_O(odd_hs),
    .EVEN_HSTART_PULSE_O(even_hs), .ODD_HCLK_OUT_O(odd_hc), .EVEN_HCLK_OUT_O(even_hc),
    .SHIFTED_DATA_CLOCK_O(sclk), .COL_LATCH_PULSE_O(lat), .COL_OUT_ENABLE_O(oen),
    .GATE_CLOCK_O(gclk), .GATE_START_O(gst), .GATE_ENABLE_A_O(gea),
    .GATE_ENABLE_B_O(geb), .DRV_CLEAR_O(clr)
  );

  lptc_link_model host_u (
    .link_clk_i(lclk), .rst_i(rst), .run_i(run), .alt_i(alt), .lane0_o(ln0),
    .lane1_o(ln1), .lane2_o(ln2), .exp_o(xv), .exp_pix_o(xp), .frame_o(frame)
  );

  // **********
  // checking helpers
  // **********
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic cmp_w(input string nm, input logic [35:0] ex, input logic [35:0] g);
    cmp_count++;
    if (g !== ex) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, ex, g);
    end
  endtask : cmp_w

  task automatic cmp_f(input string nm, input logic ex, input logic g);
    cmp_w(nm, {35'h0, ex}, {35'h0, g});
  endtask : cmp_f

  // one bus transfer; valid and payload held until ready is seen
  task automatic axi(input logic wr, input logic [3:0] a, input logic [31:0] dv,
                     input logic [3:0] s, input logic [33:0] ex);
    int n;
    if (wr) bq.push_back(ex[33:32]);
    else rq.push_back(ex);
    @(posedge clk);
    awaddr <= a;
    araddr <= a;
    wdata <= dv;
    wstrb <= s;
    {awvalid, wvalid, bready} <= {3{wr}};
    {arvalid, rready} <= {2{!wr}};
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(wr ? awready && wready : arready) && n < 99);
    @(posedge clk);
    {awvalid, wvalid, arvalid} <= 3'h0;
    do begin
      @(negedge clk);
      n++;
    end while (!(wr ? bvalid : rvalid) && n < 99);
    @(posedge clk);
    {bready, rready} <= 2'h0;
    if (n >= 99) begin
      n_mismatch++;
      complete_run();
    end
  endtask : axi

  task automatic wait_frame(input logic [7:0] f);
    int j;
    for (j = 0; j < 40000 && frame !== f; j++) @(negedge clk);
    if (frame !== f) begin
      n_mismatch++;
      complete_run();
    end
  endtask : wait_frame

  // **********
  // watchers
  // **********
  // the link side notes every pair it sends from its third frame on
  always @(posedge lclk) begin
    if (xv) pq.push_back(xp);
  end

  // bus answers, sampled mid-cycle where they are settled
  always @(negedge clk) begin
    if (bvalid && bready) cmp_w("write resp", 36'(bq.pop_front()), 36'(bresp));
    if (rvalid && rready) begin
      xr = rq.pop_front();
      cmp_w("read data", 36'(xr[31:0]), 36'(rdata));
      cmp_w("read resp", 36'(xr[33:32]), 36'(rresp));
    end
  end

  // panel side: pairs, start pulses, clocks and driver pulses
  always @(negedge clk) begin
    gap <= gap + 1;
    hc_q <= odd_hc;
    sc_q <= sclk;
    lat_q <= lat;
    gs_q <= gst;
    lat_n <= lat ? lat_n + 1 : 0;
    // the delay line adds one flop and the output flop one more: tap n lags n + 2 cycles
    if (sclk && !sc_q && cur_alt) cmp_w("clock shift", 36'(sh) + 36'h2, 36'(gap));
    if (!lat && lat_q) begin
      nlat++;
      cmp_w("latch width", {32'h0, LATCH_CYC}, 36'(lat_n));
      cmp_f("out enable", 1'b1, oen);
    end
    if (gst && !gs_q) begin
      if (nline != gs_line) cmp_w("lines per frame", 36'h4, 36'(nline - gs_line));
      gs_line = nline;
    end
    if (odd_hc && !hc_q) begin
      gap <= 1;
      cmp_f("even hclk", 1'b1, even_hc);
      if (odd_hs) begin
        left = 8;
        nline++;
        prev = 36'h0;
        cmp_f("even hstart", 1'b1, even_hs);
        cmp_f("gate clock", 1'b1, gclk);
        cmp_f("gate enable", 1'b0, gea);
      end else if (left != 0 && pq.size() != 0) begin
        left--;
        e = pq.pop_front();
        cur_alt = e[36];
        w = e[35:0];
        // more than 18 toggles against the last driven word flips it
        p = e[36] && $countones(w ^ prev) > 18;
        if (p) w = ~w;
        prev = w;
        cmp_w("pixel pair", w, {odd_d, even_d});
        cmp_w("pair spacing", 36'h20, 36'(gap));
        cmp_f("odd pol", p, odd_pol);
        cmp_f("even pol", p, even_pol);
        cmp_f("line invert", cur_alt, odd_inv ^ even_inv);
        cmp_f("gate enables", 1'b1, gea & geb);
      end
    end
  end

  // **********
  // main sequence
  // **********
  initial begin
    void'($urandom(50));
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, run, alt} = 7'h00;
    {awaddr, araddr, wstrb, sh} = 16'h0000;
    wdata = 32'h0;
    // reset spans several link edges so the link side resyncs it
    repeat (12) @(posedge lclk);
    @(negedge clk);
    cmp_f("clear in reset", 1'b1, clr);
    cmp_w("panel in reset", 36'h0, {odd_d, even_d});
    cmp_f("gate in reset", 1'b0, gclk | gst);
    @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    wait_frame(8'h05);
    axi(1'b0, 4'h4, 32'h0, 4'h0, 34'h5);
    wait_frame(8'h06);
    // let this frame's vsync pass first, so options and patterns switch at the same frame
    repeat (100) @(negedge clk);
    // options: polarity, line inversion, clock shift, two-polarity flag
    d = ($urandom & 32'hffff_ffe0) | 32'h0000_000f;
    sh = d[11:8];
    axi(1'b1, 4'h0, d, 4'hf, {RESP_OKAY, 32'h0});
    axi(1'b0, 4'h0, 32'h0, 4'h0, {2'h0, d & 32'h0000_0f1f});
    alt <= 1'b1;
    wait_frame(8'h0a);
    axi(1'b1, 4'hc, 32'hffff_ffff, 4'hf, {RESP_SLVERR, 32'h0});
    axi(1'b0, 4'hc, 32'h0, 4'h0, {RESP_SLVERR, 32'h0});
    run <= 1'b0;
    for (k = 0; k < 5000 && pq.size() != 0; k++) @(negedge clk);
    repeat (100) @(negedge clk);
    cmp_w("pairs left", 36'h0, 36'(pq.size()));
    cmp_w("lines latched", 36'(nline), 36'(nlat));
    cmp_f("lines seen", 1'b1, nline > 20);
    // blank just after a clock pulse ends, so no horizontal clock pulse is cut short
    for (k = 0; k < 100 && odd_hc !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 100 && odd_hc !== 1'b0; k++) @(negedge clk);
    if (k >= 100) n_mismatch++;
    axi(1'b1, 4'h0, 32'h0000_0010, 4'h1, {RESP_OKAY, 32'h0});
    for (k = 0; k < 100 && clr !== 1'b1; k++) @(negedge clk);
    cmp_f("soft blank clear", 1'b1, clr);
    cmp_w("soft blank panel", 36'h0, {odd_d, even_d});
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
